/* File: pcsc_card_model.sv */
// card model for both slots: memory or I/O card with wait, ready and shared line
// assumes pull-ups on the shared pins; bench picks the card kind per slot
`timescale 1ns/100ps
module pcsc_card_model (
  input  wire       clk_sys,
  input  wire [1:0] io_card,
  input  wire [1:0] cb_card,
  input  wire [1:0] card_reset_pin,
  input  wire [1:0] irq_req,
  input  wire [1:0] share_low,
  input  wire [7:0] wait_len,
  input  wire [1:0] write_strobe_n,
  input  wire [1:0] output_enable_n,
  input  wire [1:0] io_read_strobe_n,
  input  wire [1:0] io_write_strobe_n,
  input  wire [1:0] socket_clock_run_req_o,
  input  wire [1:0] socket_clock_run_req_oe,
  output wire [1:0] ready_irq_pin,
  output wire [1:0] wait_n_pin,
  output wire [1:0] wp_clkrun_pin_i
);
  for (genvar s = 0; s < 2; s++) begin : g_slot
    logic [3:0] wait_cnt_r = 4'h0;
    logic [3:0] busy_cnt_r = 4'h0;
    logic       strobe_q_r = 1'h0;
    wire        strobe = ~(write_strobe_n[s] & output_enable_n[s] &
                           io_read_strobe_n[s] & io_write_strobe_n[s]);
    // reset level follows the card kind: low for CardBus, high for 16-bit
    wire        held = cb_card[s] ? ~card_reset_pin[s] : card_reset_pin[s];
    // wait starts at the strobe's leading edge so it lands inside the strobe
    always @(posedge clk_sys) begin
      strobe_q_r <= strobe;
      if (held) wait_cnt_r <= 4'h0;
      else if (strobe && !strobe_q_r) wait_cnt_r <= wait_len[4*s +: 4];
      else if (wait_cnt_r != 4'h0) wait_cnt_r <= wait_cnt_r - 4'h1;
      if (held) busy_cnt_r <= 4'h0;
      else if (!write_strobe_n[s] && !io_card[s]) busy_cnt_r <= 4'h6;
      else if (busy_cnt_r != 4'h0) busy_cnt_r <= busy_cnt_r - 4'h1;
    end
    // shared line is wired-low between controller and card, pulled up otherwise
    assign wait_n_pin[s] = (wait_cnt_r == 4'h0);
    assign ready_irq_pin[s] = io_card[s] ? ~irq_req[s] : (busy_cnt_r == 4'h0);
    assign wp_clkrun_pin_i[s] = ~((socket_clock_run_req_oe[s] & ~socket_clock_run_req_o[s]) |
                                  share_low[s]);
  end
endmodule // pcsc_card_model

/* File: pcsc_clkgen.v */
// socket clock generator with clock-run handshake for one slot
// assumes clkrun_s is already synchronised and the pin has a pull-up outside
`timescale 1ns/100ps
`include "pcsc_consts.vh"

module pcsc_clkgen #(
  parameter [3:0] FAST_HALF  = `PCSC_FAST_HALF,
  parameter [3:0] SLOW_HALF  = `PCSC_SLOW_HALF,
  parameter [3:0] WARN_EDGES = `PCSC_WARN_EDGES
) (
  input  wire clk_sys,
  input  wire reset_n,
  input  wire cb_mode,
  input  wire stop_req,
  input  wire slow_req,
  input  wire force_run,
  input  wire clkrun_s,
  output wire rise_nxt,
  output wire sock_clk,
  output wire clkrun_oe,
  output wire stopped
);

  localparam [2:0] C_RUN  = 3'h1;
  localparam [2:0] C_WARN = 3'h2;
  localparam [2:0] C_STOP = 3'h4;

  reg [2:0] st_r;
  reg [3:0] cnt_r;
  reg       clk_r;
  reg [3:0] edge_r;
  reg       oe_r;
  reg       slow_r;
  reg       stop_r;

  // half period: full rate unless parked in slow mode
  wire [3:0] half     = ((st_r == C_STOP) && slow_r) ? SLOW_HALF : FAST_HALF;
  wire       halted   = (st_r == C_STOP) && !slow_r;
  wire       run_en   = cb_mode && !halted;
  wire       tick     = run_en && (cnt_r == (half - 4'h1));
  wire       fall_nxt = tick && clk_r;
  wire       card_req = !clkrun_s;          // card pulls the line low
  wire       want_low = stop_req || slow_req;
  wire       leave    = force_run || card_req || !want_low || (slow_req != slow_r);

  assign rise_nxt = tick && !clk_r;

  // clock divider and clock-run state; 16-bit mode parks everything
  always @(posedge clk_sys) begin
    if (!reset_n || !cb_mode) begin
      st_r   <= C_RUN;
      cnt_r  <= 4'h0;
      clk_r  <= 1'b0;
      edge_r <= 4'h0;
      oe_r   <= 1'b0;
      slow_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      cnt_r <= tick ? 4'h0 : (run_en ? cnt_r + 4'h1 : 4'h0);
      if (tick) begin
        clk_r <= !clk_r; // R15
      end
      case (st_r)
        C_RUN: begin
          oe_r   <= 1'b1;                   // drive low: clock running
          edge_r <= 4'h0;
          stop_r <= 1'b0;
          if (want_low && !force_run) begin
            st_r   <= C_WARN;               // R16
            slow_r <= slow_req;
          end
        end
        C_WARN: begin
          oe_r <= 1'b0;                     // release: announce slowing
          if (rise_nxt && (edge_r != 4'hf)) begin
            edge_r <= edge_r + 4'h1;
          end
          // card may still hold the line low, which cancels the slow-down
          if (force_run || !want_low || ((edge_r >= `PCSC_WARN_SETTLE) && card_req)) begin
            st_r <= C_RUN; // R16
          end else if ((edge_r >= WARN_EDGES) && fall_nxt) begin
            st_r   <= C_STOP;               // stops only after a falling edge, so low
            stop_r <= !slow_r; // R15
          end
        end
        C_STOP: begin
          oe_r <= 1'b0;
          if (leave) begin
            st_r   <= C_RUN; // R16
            stop_r <= 1'b0;
            oe_r   <= 1'b1;
          end
        end
        default: begin
          st_r <= C_RUN;
        end
      endcase
    end
  end

  assign sock_clk  = clk_r;
  assign clkrun_oe = oe_r;
  assign stopped   = stop_r;

endmodule // pcsc_clkgen

/* File: pcsc_consts.vh */
// constants for the two-slot socket control block: modes, operations, timing counts
// assumes clk_sys at 10 MHz; included by every design file of the block
// Function
// R1: two independent sockets, A and B, each with full control and system signals.
// R2: ready/irq input means ready only in memory-only mode, else interrupt request.
// R3: memory card holds ready low while busy with a previous write.
// R4: memory card drives ready high once it accepts a new command.
// R5: I/O card asserts irq when service needed, holds it high otherwise.
// R6: attribute select stays high for every common memory access.
// R7: attribute select low picks attribute memory or I/O space per strobe.
// R8: controller can hard-reset an inserted 16-bit card via the reset output.
// R9: operating voltage is decoded from both sense lines taken together.
// R10: card wait extends the cycle; controller never completes it while held.
// R11: write strobe pulses latch memory write data into memory cards.
// R12: on memory cards the shared line reports the write-protect switch.
// R13: I/O card flags 16-bit port only for a matching, 16-bit capable address.
// R14: in CardBus mode sample on rising socket clock, except the listed async lines.
// R15: socket clock runs at host clock rate, may stop low or slow; pcsc_clkgen runs it at half the clk_sys rate at most.
// R16: card uses clock-run to request speed; controller uses it to announce slowing.
// R17: card returns its registers and sequencers to known state during bus reset.
// R18: during bus reset controller drives the CardBus signals to valid levels.
// R19: bus reset may assert asynchronously but releases synchronous to socket clock.
// R20: output enable driven low to make a memory card output read data.
// R21: I/O write strobe driven low to latch write data into an I/O card.
// R22: each shared pin's function follows the socket's configured interface type.
`ifndef PCSC_CONSTS_VH
`define PCSC_CONSTS_VH

// interface type of a socket
`define PCSC_MODE_MEM     2'h0
`define PCSC_MODE_IO      2'h1
`define PCSC_MODE_CB      2'h2

// host access kinds; bit 1 set means I/O space
`define PCSC_OP_MRD       2'h0
`define PCSC_OP_MWR       2'h1
`define PCSC_OP_IO_READ_STROBE      2'h2
`define PCSC_OP_IO_WRITE_STROBE      2'h3

// strobe timing: least strobe time in ns, rounded up to clk_sys cycles
`define PCSC_CLK_NS       100
`define PCSC_STROBE_NS    250
`define PCSC_STROBE_CYC   ((`PCSC_STROBE_NS + `PCSC_CLK_NS - 1) / `PCSC_CLK_NS)

// socket clock half periods in clk_sys cycles, and clock-run warning length
`define PCSC_FAST_HALF    4'h1
`define PCSC_SLOW_HALF    4'h8
`define PCSC_WARN_EDGES   4'h4
`define PCSC_WARN_SETTLE  4'h2

// reset values
`define PCSC_RST_STROBE_N 1'h1
`define PCSC_RST_ATTR_N   1'h1

`endif

/* File: pcsc_sync.v */
// two-flop synchroniser for a bundle of pin levels
// assumes each bit is an independent level; no bit-to-bit coherence is promised
`timescale 1ns/100ps
`include "pcsc_consts.vh"

module pcsc_sync #(
  parameter W = 1
) (
  input  wire         clk_sys,
  input  wire         reset_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] stage1_r;
  reg [W-1:0] stage2_r;

  // first stage feeds only the second stage
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      stage1_r <= {W{1'b0}};
      stage2_r <= {W{1'b0}};
    end else begin
      stage1_r <= d;
      stage2_r <= stage1_r;
    end
  end

  assign q = stage2_r;

endmodule // pcsc_sync

/* File: pcsc_top.v */
// two-slot socket control: 16-bit strobes, card status and CardBus system lines
// assumes static mode inputs per slot and a pull-up on every shared pin outside
`timescale 1ns/100ps
`include "pcsc_consts.vh"

module pcsc_top (
  input  wire       clk_sys,
  input  wire       reset_n,
  // host side, slot A in the low bits, slot B above
  input  wire [3:0] host_mode,
  input  wire [1:0] host_req_valid,
  input  wire [3:0] host_req_op,
  input  wire [1:0] host_req_attr,
  input  wire [1:0] host_card_reset,
  input  wire [1:0] host_clk_stop,
  input  wire [1:0] host_clk_slow,
  // host side status, one bit per slot except the two-bit voltage code
  output wire [1:0] host_busy,
  output wire [1:0] host_done,
  output wire [1:0] host_refused,
  output wire [1:0] card_ready,
  output wire [1:0] card_irq_request,
  output wire [1:0] write_protect,
  output wire [1:0] io_port_wide_ind,
  output wire [3:0] voltage_code,
  output wire [1:0] voltage_valid,
  output wire [1:0] clock_stopped,
  // socket pins
  input  wire [1:0] ready_irq_pin,
  input  wire [1:0] wait_n_pin,
  input  wire [1:0] wp_clkrun_pin_i,
  input  wire [1:0] voltage_sense_one,
  input  wire [1:0] voltage_sense_two,
  // socket strobes and selects, active low
  output wire [1:0] attr_select_n,
  output wire [1:0] output_enable_n,
  output wire [1:0] write_strobe_n,
  output wire [1:0] io_read_strobe_n,
  output wire [1:0] io_write_strobe_n,
  // card reset and CardBus system lines
  output wire [1:0] card_reset_pin,
  output wire [1:0] socket_bus_clock,
  output wire [1:0] socket_clock_run_req_o,
  output wire [1:0] socket_clock_run_req_oe
);

  localparam [4:0] S_IDLE   = 5'h01;
  localparam [4:0] S_SETUP  = 5'h02;
  localparam [4:0] S_STROBE = 5'h04;
  localparam [4:0] S_WAITX  = 5'h08;
  localparam [4:0] S_HOLD   = 5'h10;
  localparam [31:0] STB_CYC  = `PCSC_STROBE_CYC;
  localparam [3:0]  STB_LAST = STB_CYC[3:0] - 4'h1;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: every socket input is asynchronous to clk_sys

  wire [9:0] sync_q;

  pcsc_sync #(
    .W (10)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d       ({voltage_sense_two, voltage_sense_one, wp_clkrun_pin_i,
                wait_n_pin, ready_irq_pin}),
    .q       (sync_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // one identical socket per slot

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_slot // R1
      wire [1:0] mode     = host_mode[2*i+1:2*i];
      wire [1:0] op       = host_req_op[2*i+1:2*i];
      wire       is_mem   = (mode == `PCSC_MODE_MEM);
      wire       is_io    = (mode == `PCSC_MODE_IO);
      wire       is_cb    = (mode == `PCSC_MODE_CB);
      wire       op_io    = op[1];
      wire       ready_s  = sync_q[i];
      wire       wait_s   = sync_q[2+i];
      wire       wp_s     = sync_q[4+i];
      wire       vs1_s    = sync_q[6+i];
      wire       vs2_s    = sync_q[8+i];
      // I/O space needs an I/O socket; CardBus takes no 16-bit cycles
      wire       legal    = op_io ? is_io : (is_mem || is_io); // R22
      // socket clock generator outputs
      wire       rise_nxt;
      wire       sclk;
      wire       cr_oe;
      wire       stopped;

      // sequencer and pin registers
      reg  [4:0] state_r;
      reg  [3:0] cnt_r;
      reg  [1:0] op_r;
      reg        busy_r;
      reg        done_r;
      reg        refused_r;
      reg        attr_n_r;
      reg        oe_n_r;
      reg        we_n_r;
      reg        io_read_strobe_n_r;
      reg        io_write_strobe_n_r;
      reg        rst_act_r;
      reg        rst_pin_r;
      reg        rst_nxt;
      // card status registers
      reg        ready_r;
      reg        irq_r;
      reg        wp_r;
      reg        wide_r;
      reg  [1:0] vs_prev_r;
      reg  [1:0] vs_code_r;
      reg        vs_valid_r;
      // clock-run drive level
      reg        cr_lvl_r;

      // reset request: takes effect on the next clk_sys edge whatever the
      // socket clock phase, but a CardBus release waits for a rising edge
      always @* begin
        rst_nxt = rst_act_r;
        if (host_card_reset[i]) begin
          rst_nxt = 1'b1; // R8
        end else if (!is_cb || rise_nxt) begin
          rst_nxt = 1'b0; // R19
        end
      end

      // access sequencer: setup, strobe, wait extension, hold
      always @(posedge clk_sys) begin
        if (!reset_n) begin
          state_r   <= S_IDLE;
          cnt_r     <= 4'h0;
          op_r      <= `PCSC_OP_MRD;
          busy_r    <= 1'b0;
          done_r    <= 1'b0;
          refused_r <= 1'b0;
          attr_n_r  <= `PCSC_RST_ATTR_N;
          oe_n_r    <= `PCSC_RST_STROBE_N;
          we_n_r    <= `PCSC_RST_STROBE_N;
          io_read_strobe_n_r  <= `PCSC_RST_STROBE_N;
          io_write_strobe_n_r  <= `PCSC_RST_STROBE_N;
          rst_act_r <= 1'b1;
          rst_pin_r <= !is_cb;
        end else begin
          done_r    <= 1'b0;
          refused_r <= 1'b0;
          rst_act_r <= rst_nxt;
          // pin polarity follows the interface: high resets a 16-bit card,
          // low is the CardBus bus reset
          rst_pin_r <= is_cb ? !rst_nxt : rst_nxt; // R22
          case (state_r)
            S_IDLE: begin
              if (host_req_valid[i]) begin
                if (legal && !rst_act_r) begin
                  op_r     <= op;
                  busy_r   <= 1'b1;
                  // common memory keeps the select high; attribute or I/O drops it
                  attr_n_r <= !(op_io || host_req_attr[i]); // R6 R7
                  state_r  <= S_SETUP;
                end else begin
                  refused_r <= 1'b1;
                end
              end
            end
            S_SETUP: begin
              // exactly one strobe falls, chosen by the access kind
              oe_n_r   <= (op_r != `PCSC_OP_MRD);  // R20
              we_n_r   <= (op_r != `PCSC_OP_MWR);  // R11
              io_read_strobe_n_r <= (op_r != `PCSC_OP_IO_READ_STROBE); // R7
              io_write_strobe_n_r <= (op_r != `PCSC_OP_IO_WRITE_STROBE); // R21
              cnt_r    <= STB_LAST;
              state_r  <= S_STROBE;
            end
            S_STROBE: begin
              // strobe held for its least width before wait counts
              if (cnt_r == 4'h0) begin
                state_r <= S_WAITX;
              end else begin
                cnt_r <= cnt_r - 4'h1;
              end
            end
            S_WAITX: begin
              // no timeout: a card that never lets go stalls this slot only
              if (wait_s) begin
                oe_n_r   <= 1'b1; // R10
                we_n_r   <= 1'b1;
                io_read_strobe_n_r <= 1'b1;
                io_write_strobe_n_r <= 1'b1;
                state_r  <= S_HOLD;
              end
            end
            S_HOLD: begin
              // strobes are already high; the select goes last
              attr_n_r <= 1'b1;
              busy_r   <= 1'b0;
              done_r   <= 1'b1;
              state_r  <= S_IDLE;
            end
            default: begin
              state_r <= S_IDLE;
            end
          endcase
        end
      end

      // card status; the interrupt line is asynchronous in CardBus mode too,
      // so it is taken on clk_sys and not on the socket clock edge
      always @(posedge clk_sys) begin
        if (!reset_n) begin
          ready_r    <= 1'b0;
          irq_r      <= 1'b0;
          wp_r       <= 1'b0;
          wide_r     <= 1'b0;
          vs_prev_r  <= 2'h0;
          vs_code_r  <= 2'h0;
          vs_valid_r <= 1'b0;
          cr_lvl_r   <= 1'b0;
        end else begin
          ready_r   <= is_mem && ready_s;    // R2 R4
          irq_r     <= !is_mem && !ready_s;  // R2 R5 R14
          wp_r      <= is_mem && wp_s;       // R12
          wide_r    <= is_io && !wp_s;       // R13
          cr_lvl_r  <= 1'b0;                 // clock-run only ever driven low
          // voltage sense pair tracking
          vs_prev_r <= {vs2_s, vs1_s};
          // a pair seen twice in a row is coherent; a mixed code mid-change is not
          vs_valid_r <= ({vs2_s, vs1_s} == vs_prev_r); // R9
          if ({vs2_s, vs1_s} == vs_prev_r) begin
            vs_code_r <= vs_prev_r; // R9
          end
        end
      end

      // bus reset keeps the clock running and clock-run driven, so the
      // lines the card floats are held at valid levels
      pcsc_clkgen #(
        .FAST_HALF  (`PCSC_FAST_HALF),
        .SLOW_HALF  (`PCSC_SLOW_HALF),
        .WARN_EDGES (`PCSC_WARN_EDGES)
      ) u_clkgen (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .cb_mode   (is_cb),
        .stop_req  (host_clk_stop[i]),
        .slow_req  (host_clk_slow[i]),
        .force_run (rst_act_r), // R18
        .clkrun_s  (wp_s),
        .rise_nxt  (rise_nxt),
        .sock_clk  (sclk),
        .clkrun_oe (cr_oe),
        .stopped   (stopped)
      );

      // host status, all straight from flip-flops
      assign host_busy[i]               = busy_r;
      assign host_done[i]               = done_r;
      assign host_refused[i]            = refused_r;
      assign card_ready[i]              = ready_r;
      assign card_irq_request[i]        = irq_r;
      assign write_protect[i]           = wp_r;
      assign io_port_wide_ind[i]        = wide_r;
      assign voltage_code[2*i+1:2*i]    = vs_code_r;
      assign voltage_valid[i]           = vs_valid_r;
      assign clock_stopped[i]           = stopped;
      // socket pin outputs
      assign attr_select_n[i]           = attr_n_r;
      assign output_enable_n[i]         = oe_n_r;
      assign write_strobe_n[i]          = we_n_r;
      assign io_read_strobe_n[i]        = io_read_strobe_n_r;
      assign io_write_strobe_n[i]       = io_write_strobe_n_r;
      assign card_reset_pin[i]          = rst_pin_r;
      assign socket_bus_clock[i]        = sclk;
      assign socket_clock_run_req_o[i]  = cr_lvl_r;
      assign socket_clock_run_req_oe[i] = cr_oe;
    end
  endgenerate

endmodule // pcsc_top

/* File: pcsc_top_monitor.sv */
// checker on the top ports: slot A 16-bit relations, slot B CardBus clock
// assumes bind into pcsc_top; both slots share the same logic
`timescale 1ns/100ps
`include "pcsc_consts.vh"
module pcsc_top_monitor (
  input wire       clk_sys,
  input wire       reset_n,
  input wire [3:0] host_mode,
  input wire [3:0] host_req_op,
  input wire [1:0] host_req_attr,
  input wire [1:0] host_card_reset,
  input wire [1:0] host_busy,
  input wire [1:0] host_done,
  input wire [1:0] card_ready,
  input wire [3:0] voltage_code,
  input wire [1:0] voltage_sense_one,
  input wire [1:0] voltage_sense_two,
  input wire [1:0] wait_n_pin,
  input wire [1:0] attr_select_n,
  input wire [1:0] output_enable_n,
  input wire [1:0] write_strobe_n,
  input wire [1:0] io_write_strobe_n,
  input wire [1:0] card_reset_pin,
  input wire [1:0] socket_bus_clock,
  input wire [1:0] socket_clock_run_req_oe,
  input wire [1:0] clock_stopped
);
  default clocking mon_cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // strobes and status
  property p_ready_mode;
    host_mode[1:0] != `PCSC_MODE_MEM && $stable(host_mode) |=> !card_ready[0];
  endproperty
  a_ready_mode: assert property (p_ready_mode) else $error("ready shown outside memory mode");
  property p_attr_common;
    $rose(host_busy[0]) && !$past(host_req_attr[0]) && !$past(host_req_op[1])
      |-> attr_select_n[0] [*5];
  endproperty
  a_attr_common: assert property (p_attr_common) else $error("attr select low in common access");
  property p_reset16;
    host_card_reset[0] && host_mode[1:0] != `PCSC_MODE_CB |-> ##[1:2] card_reset_pin[0];
  endproperty
  a_reset16: assert property (p_reset16) else $error("card reset not driven");
  property p_volt;
    $stable({voltage_sense_two[0], voltage_sense_one[0]}) [*6]
      |-> voltage_code[1:0] == {voltage_sense_two[0], voltage_sense_one[0]};
  endproperty
  a_volt: assert property (p_volt) else $error("voltage code not the sense pair");
  property p_wait;
    !wait_n_pin[0] [*5] |=> !host_done[0];
  endproperty
  a_wait: assert property (p_wait) else $error("cycle completed during wait");
  property p_we;
    !write_strobe_n[0] |-> host_busy[0] && output_enable_n[0];
  endproperty
  a_we: assert property (p_we) else $error("write strobe outside a write");
  property p_oe;
    $fell(output_enable_n[0]) |-> host_busy[0] ##0 !output_enable_n[0] [*3];
  endproperty
  a_oe: assert property (p_oe) else $error("output enable pulse too short");
  property p_iow;
    $fell(io_write_strobe_n[0]) |-> host_mode[1:0] == `PCSC_MODE_IO ##0 !io_write_strobe_n[0] [*3];
  endproperty
  a_iow: assert property (p_iow) else $error("io write strobe wrong");

  // socket clock of slot B
  property p_stop_low;
    clock_stopped[1] && $past(clock_stopped[1])
      |-> !socket_bus_clock[1] && $stable(socket_bus_clock[1]);
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("stopped clock not held low");
  property p_clkrun;
    $rose(clock_stopped[1]) |-> !socket_clock_run_req_oe[1] && !$past(socket_clock_run_req_oe[1], 4);
  endproperty
  a_clkrun: assert property (p_clkrun) else $error("clock stopped without warning");
  property p_cb_release;
    host_mode[3:2] == `PCSC_MODE_CB && $rose(card_reset_pin[1]) |-> $rose(socket_bus_clock[1]);
  endproperty
  a_cb_release: assert property (p_cb_release) else $error("bus reset release off clock rise");
endmodule // pcsc_top_monitor

bind pcsc_top pcsc_top_monitor i_pcsc_top_monitor (.*);

/* File: pcsc_top_tb_top.sv */
// bench: slot A runs 16-bit memory then I/O, slot B runs CardBus
// assumes the card model on the socket pins and the bound checker
`timescale 1ns/100ps
module pcsc_top_tb_top;
  logic       clk_sys = 1'h0;
  logic       reset_n = 1'h0;
  logic [3:0] host_mode = 4'h8;
  logic [3:0] host_req_op = 4'h0;
  logic [1:0] host_req_valid = 2'h0, host_req_attr = 2'h0, host_card_reset = 2'h0;
  logic [1:0] host_clk_stop = 2'h0, host_clk_slow = 2'h0, io_card = 2'h0, irq_req = 2'h0;
  logic [1:0] share_low = 2'h0, voltage_sense_one = 2'h2, voltage_sense_two = 2'h1;
  logic [7:0] wait_len = 8'h0;
  logic [1:0] cb_card = 2'h2;
  wire  [1:0] host_busy, host_done, host_refused, card_ready, card_irq_request;
  wire  [1:0] write_protect, io_port_wide_ind, voltage_valid, clock_stopped, attr_select_n;
  wire  [1:0] output_enable_n, write_strobe_n, io_read_strobe_n, io_write_strobe_n;
  wire  [1:0] card_reset_pin, socket_bus_clock, socket_clock_run_req_o, socket_clock_run_req_oe;
  wire  [1:0] ready_irq_pin, wait_n_pin, wp_clkrun_pin_i;
  wire  [3:0] voltage_code;
  int         errors = 0;
  int         n_checks = 0;

  pcsc_top        i_pcsc_top (.*);
  pcsc_card_model i_pcsc_card_model (.*);

  // 10 MHz system clock
  initial forever #50 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // a used-up bound ends the run at once rather than cascading
  task automatic hung(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      $display("ERROR wait_bound expected %0d seen %0d", lim - 1, n);
      wrap_up;
    end
  endtask

  // mode changes only under reset, since the mode inputs are static
  task automatic rst(input logic [3:0] mode);
    reset_n = 1'h0;
    host_mode = mode;
    repeat (10) @(negedge clk_sys);
    reset_n = 1'h1;
    repeat (4) @(negedge clk_sys);
  endtask

  // one access: records every strobe seen, checks kind, refusal and length
  task automatic acc(input int s, input logic [1:0] op, input logic at,
                     input logic [3:0] wl, input logic rf);
    int         n;
    logic [4:0] seen;
    n = 0;
    seen = 5'h0;
    wait_len[4*s +: 4] = wl;
    host_req_op[2*s +: 2] = op;
    host_req_attr[s] = at;
    host_req_valid[s] = 1'h1;
    @(negedge clk_sys);
    host_req_valid[s] = 1'h0;
    while (host_done[s] !== 1'h1 && host_refused[s] !== 1'h1 && n < 60) begin
      seen = seen | {~attr_select_n[s], ~io_write_strobe_n[s], ~io_read_strobe_n[s],
                     ~write_strobe_n[s], ~output_enable_n[s]};
      n++;
      @(negedge clk_sys);
    end
    hung(n, 60);
    chk("refused", host_refused[s], rf);
    chk("busy_end", host_busy[s], 1'h0);
    if (!rf) begin
      chk("strobes", seen, {op[1] | at, op == 2'h3, op == 2'h2, op == 2'h1,
                            op == 2'h0});
      chk("cycle_len", n >= 4 + wl && n >= 6, 1'h1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // memory card: back-to-back accesses, wait, refusals, ready, protect, voltage
  task automatic t_mem;
    acc(0, 2'h0, 1'h0, 4'h0, 1'h0);
    acc(0, 2'h1, 1'h1, 4'h6, 1'h0);
    acc(0, 2'h0, 1'h1, 4'h2, 1'h0);
    acc(0, 2'h2, 1'h0, 4'h0, 1'h1);
    acc(0, 2'h3, 1'h0, 4'h0, 1'h1);
    acc(0, 2'h1, 1'h0, 4'h0, 1'h0);
    chk("ready_busy", card_ready[0], 1'h0);
    repeat (12) @(negedge clk_sys);
    chk("ready", card_ready[0], 1'h1);
    chk("irq_mem", card_irq_request[0], 1'h0);
    chk("wp_on", write_protect[0], 1'h1);
    share_low[0] = 1'h1;
    repeat (4) @(negedge clk_sys);
    chk("wp_off", write_protect[0], 1'h0);
    share_low[0] = 1'h0;
    chk("vcode", voltage_code, 4'h6);
    chk("vvalid", voltage_valid, 2'h3);
  endtask

  // I/O card: both strobes, irq, wide port, card reset with refusal
  task automatic t_io;
    io_card[0] = 1'h1;
    rst(4'h9);
    acc(0, 2'h2, 1'h0, 4'h2, 1'h0);
    acc(0, 2'h3, 1'h0, 4'h0, 1'h0);
    irq_req[0] = 1'h1;
    share_low[0] = 1'h1;
    repeat (4) @(negedge clk_sys);
    chk("irq", card_irq_request[0], 1'h1);
    chk("wide", io_port_wide_ind[0], 1'h1);
    chk("ready_io", card_ready[0], 1'h0);
    irq_req[0] = 1'h0;
    share_low[0] = 1'h0;
    host_card_reset[0] = 1'h1;
    repeat (4) @(negedge clk_sys);
    chk("irq_off", card_irq_request[0], 1'h0);
    chk("rst16", card_reset_pin[0], 1'h1);
    acc(0, 2'h2, 1'h0, 4'h0, 1'h1);
    host_card_reset[0] = 1'h0;
    repeat (3) @(negedge clk_sys);
    chk("rst16_off", card_reset_pin[0], 1'h0);
  endtask

  // CardBus slot: refusal, clock rate, stop with warning, card wake, bus reset
  task automatic t_cb;
    int   n;
    int   tg;
    logic p;
    logic ann;
    acc(1, 2'h0, 1'h0, 4'h0, 1'h1);
    tg = 0;
    p = socket_bus_clock[1];
    repeat (20) begin
      @(negedge clk_sys);
      if (socket_bus_clock[1] !== p) tg++;
      p = socket_bus_clock[1];
    end
    chk("clk_fast", tg >= 18, 1'h1);
    host_clk_stop[1] = 1'h1;
    n = 0;
    ann = 1'h0;
    while (clock_stopped[1] !== 1'h1 && n < 40) begin
      ann = ann | ~socket_clock_run_req_oe[1];
      n++;
      @(negedge clk_sys);
    end
    hung(n, 40);
    chk("announce", ann, 1'h1);
    chk("cr_level", socket_clock_run_req_o[1], 1'h0);
    chk("stop_low", socket_bus_clock[1], 1'h0);
    share_low[1] = 1'h1;
    n = 0;
    while (clock_stopped[1] !== 1'h0 && n < 20) begin
      n++;
      @(negedge clk_sys);
    end
    hung(n, 20);
    share_low[1] = 1'h0;
    host_clk_stop[1] = 1'h0;
    host_card_reset[1] = 1'h1;
    repeat (3) @(negedge clk_sys);
    chk("cb_rst", card_reset_pin[1], 1'h0);
    host_card_reset[1] = 1'h0;
    n = 0;
    while (card_reset_pin[1] !== 1'h1 && n < 40) begin
      n++;
      @(negedge clk_sys);
    end
    hung(n, 40);
    chk("rel_on_rise", socket_bus_clock[1], 1'h1);
  endtask

  // main sequence
  initial begin
    rst(4'h8);
    t_mem;
    t_io;
    t_cb;
    wrap_up;
  end
endmodule // pcsc_top_tb_top
